//--- verilog/instr_decoder.sv
// 14-bit instruction decoder with instruction cycle sequencing.
// Assumes fetch and datapath on the same clock; skip_cond valid in the last phase.
`timescale 1ns/1ps

module instr_decoder
  import decoder_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`INSTR_W-1:0] instr_word,
  input wire logic instr_valid,
  input wire logic skip_cond,
  input wire logic [1:0] ptr_in_prog,
  output logic [`PHASE_W-1:0] phase,
  output logic cycle_last,
  output logic fetch_take,
  output logic exec_valid,
  output logic nop_cycle,
  output logic stall_cycle,
  output fmt_t fmt,
  output logic [`INSTR_W-1:0] opcode,
  output logic dest_file,
  output logic [`FILE_MSB:0] file_addr,
  output logic [2:0] bit_num,
  output logic [10:0] literal,
  output logic ptr_sel,
  output logic [1:0] ptr_mode,
  output logic file_read,
  output logic file_write,
  output logic w_write,
  output logic changes_pc,
  output logic skip_kind,
  output logic [1:0] cycles
);

  // ========================================================================
  // Decode functions
  function automatic fmt_t decode_fmt(input logic [`INSTR_W-1:0] w);
    fmt_t f;
    f = FMT_OPONLY;
    casez (w)
      `PAT_PTR_INC: f = FMT_PTR_INC;
      `PAT_BANK: f = FMT_BANK;
      `PAT_OPONLY: f = FMT_OPONLY;
      `PAT_BYTE: f = FMT_BYTE;
      `PAT_BIT: f = FMT_BIT;
      `PAT_JUMP: f = FMT_JUMP;
      `PAT_REL: f = FMT_REL;
      `PAT_PAGE: f = FMT_PAGE;
      `PAT_ADD_PTR: f = FMT_PTR_OFS;
      `PAT_PTR_MEM: f = FMT_PTR_OFS;
      `PAT_BYTE_X1: f = FMT_BYTE;
      `PAT_BYTE_X2: f = FMT_BYTE;
      `PAT_BYTE_X3: f = FMT_BYTE;
      `PAT_BYTE_X4: f = FMT_BYTE;
      `PAT_LIT: f = FMT_LIT;
      default: f = FMT_OPONLY;
    endcase
    return f;
  endfunction : decode_fmt

  function automatic logic is_two_cycle(input logic [`INSTR_W-1:0] w);
    logic r;
    r = 1'b0;
    casez (w)
      `PAT_CALL: r = 1'b1;
      `OP_WREG_CALL: r = 1'b1;
      `OP_SUB_RETURN: r = 1'b1;
      `OP_INT_RETURN: r = 1'b1;
      `PAT_RETLIT: r = 1'b1;
      `PAT_JUMP_ABS: r = 1'b1;
      `PAT_REL: r = 1'b1;
      `OP_WREG_BRANCH: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_two_cycle

  function automatic logic is_skip(input logic [`INSTR_W-1:0] w);
    logic r;
    r = 1'b0;
    casez (w)
      `PAT_DEC_SKIP: r = 1'b1;
      `PAT_INC_SKIP: r = 1'b1;
      `PAT_SKIP_CLR: r = 1'b1;
      `PAT_SKIP_SET: r = 1'b1;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : is_skip

  function automatic logic is_indirect_addr(input logic [`FILE_MSB:0] a);
    return (a == `INDIRECT0_ADDR) || (a == `INDIRECT1_ADDR);
  endfunction : is_indirect_addr

  // ========================================================================
  // Phase generator
  quad_phase_gen u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .phase(phase),
    .cycle_last(cycle_last)
  );

  // ========================================================================
  // Field extraction of the presented word
  fmt_t fmt_w;
  logic [`INSTR_W-1:0] op_w;
  logic dest_w;
  logic [`FILE_MSB:0] faddr_w;
  logic [2:0] bitn_w;
  logic [10:0] lit_w;
  logic psel_w;
  logic [1:0] pmode_w;
  logic fread_w;
  logic fwrite_w;
  logic wwrite_w;
  logic ptr_mem_w;
  logic ind_w;
  logic two_w;
  logic skip_w;
  logic clrw_w;

  always_comb begin
    fmt_w = decode_fmt(instr_word);
    two_w = is_two_cycle(instr_word);
    skip_w = is_skip(instr_word);
    clrw_w = 1'b0;
    op_w = instr_word;
    dest_w = 1'b0;
    faddr_w = `FILE_ADDR_MIN;
    bitn_w = 3'h0;
    lit_w = 11'h000;
    psel_w = 1'b0;
    pmode_w = 2'h0;
    fread_w = 1'b0;
    fwrite_w = 1'b0;
    wwrite_w = 1'b0;
    ptr_mem_w = 1'b0;
    casez (instr_word)
      `PAT_CLRW: clrw_w = 1'b1;
      default: clrw_w = 1'b0;
    endcase
    case (fmt_w)
      FMT_BYTE: begin
        op_w = instr_word >> `BYTE_OP_LSB;
        dest_w = instr_word[`BYTE_D_BIT];
        if (clrw_w) begin
          wwrite_w = 1'b1;
        end else begin
          faddr_w = instr_word[`FILE_MSB:0];
          fread_w = 1'b1;
          fwrite_w = dest_w;
          wwrite_w = ~dest_w;
        end
      end
      FMT_BIT: begin
        op_w = instr_word >> `BIT_OP_LSB;
        bitn_w = instr_word[`BIT_NUM_MSB:`BIT_NUM_LSB];
        faddr_w = instr_word[`FILE_MSB:0];
        fread_w = 1'b1;
        fwrite_w = ~instr_word[`BIT_SKIP_BIT];
      end
      FMT_LIT: begin
        op_w = instr_word >> `BYTE_OP_LSB;
        lit_w = {3'h0, instr_word[`LIT_MSB:0]};
      end
      FMT_JUMP: begin
        op_w = instr_word >> `JUMP_OP_LSB;
        lit_w = instr_word[`JUMP_K_MSB:0];
      end
      FMT_PAGE: begin
        op_w = instr_word >> `PAGE_OP_LSB;
        lit_w = {4'h0, instr_word[`PAGE_K_MSB:0]};
      end
      FMT_BANK: begin
        op_w = instr_word >> `BANK_OP_LSB;
        lit_w = {6'h00, instr_word[`BANK_K_MSB:0]};
      end
      FMT_REL: begin
        op_w = instr_word >> `REL_OP_LSB;
        lit_w = {2'h0, instr_word[`REL_K_MSB:0]};
      end
      FMT_PTR_OFS: begin
        op_w = instr_word >> `PTRO_OP_LSB;
        psel_w = instr_word[`PTRO_N_BIT];
        lit_w = {5'h00, instr_word[`PTRO_K_MSB:0]};
        ptr_mem_w = instr_word[`PTRO_MEM_BIT];
      end
      FMT_PTR_INC: begin
        op_w = instr_word >> `PTRI_OP_LSB;
        psel_w = instr_word[`PTRI_N_BIT];
        pmode_w = instr_word[`PTRI_M_MSB:0];
        ptr_mem_w = 1'b1;
      end
      default: begin
        op_w = instr_word;
      end
    endcase
    // Pointer-based memory access or indirect file access into program memory
    ind_w = (ptr_mem_w & ptr_in_prog[psel_w]) |
            (fread_w & is_indirect_addr(faddr_w) & ptr_in_prog[faddr_w[0]]);
  end

  // ========================================================================
  // Instruction cycle sequencer
  dec_state_t q;
  dec_state_t d;
  logic flush_now;

  always_comb begin
    d = q;
    d.fetch_take = 1'b0;
    // Skip outcome is taken from the last phase of the executing cycle
    flush_now = q.flush_pend | ((q.seq == ST_EXEC) & q.skip_kind & skip_cond);
    if (cycle_last) begin
      d.exec_valid = 1'b0;
      d.nop_cycle = 1'b0;
      d.stall_cycle = 1'b0;
      case (1'b1)
        q.extra_pend: begin
          d.seq = ST_EXTRA;
          d.stall_cycle = 1'b1;
          d.extra_pend = 1'b0;
          d.flush_pend = flush_now;
        end
        flush_now: begin
          d.seq = ST_FLUSH;
          d.nop_cycle = 1'b1;
          d.flush_pend = 1'b0;
        end
        instr_valid: begin
          d.seq = ST_EXEC;
          d.exec_valid = 1'b1;
          d.fetch_take = 1'b1;
          d.fmt = fmt_w;
          d.opcode = op_w;
          d.dest_file = dest_w;
          d.file_addr = faddr_w;
          d.bit_num = bitn_w;
          d.literal = lit_w;
          d.ptr_sel = psel_w;
          d.ptr_mode = pmode_w;
          d.file_read = fread_w;
          d.file_write = fwrite_w;
          d.w_write = wwrite_w;
          d.changes_pc = two_w;
          d.skip_kind = skip_w;
          d.cycles = `CYC_ONE + {1'b0, two_w} + {1'b0, ind_w};
          d.extra_pend = ind_w;
          d.flush_pend = two_w;
        end
        default: begin
          d.seq = ST_IDLE;
          d.nop_cycle = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{seq: ST_IDLE, fmt: FMT_OPONLY, opcode: 14'h0000, dest_file: 1'b0,
             file_addr: `FILE_ADDR_MIN, bit_num: 3'h0, literal: 11'h000,
             ptr_sel: 1'b0, ptr_mode: 2'h0, file_read: 1'b0, file_write: 1'b0,
             w_write: 1'b0, changes_pc: 1'b0, skip_kind: 1'b0, cycles: `CYC_ONE,
             extra_pend: 1'b0, flush_pend: 1'b0, exec_valid: 1'b0,
             nop_cycle: 1'b1, stall_cycle: 1'b0, fetch_take: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Outputs
  assign fetch_take = q.fetch_take;
  assign exec_valid = q.exec_valid;
  assign nop_cycle = q.nop_cycle;
  assign stall_cycle = q.stall_cycle;
  assign fmt = q.fmt;
  assign opcode = q.opcode;
  assign dest_file = q.dest_file;
  assign file_addr = q.file_addr;
  assign bit_num = q.bit_num;
  assign literal = q.literal;
  assign ptr_sel = q.ptr_sel;
  assign ptr_mode = q.ptr_mode;
  assign file_read = q.file_read;
  assign file_write = q.file_write;
  assign w_write = q.w_write;
  assign changes_pc = q.changes_pc;
  assign skip_kind = q.skip_kind;
  assign cycles = q.cycles;

endmodule : instr_decoder

//--- common/decoder_map.svh
// Constants of the 14-bit instruction decoder: field positions, opcode patterns, reset values.
// Assumes inclusion by decoder_pkg and by the design modules, bare name on the include path.
`ifndef DECODER_MAP_SVH
`define DECODER_MAP_SVH

// ==========================================================================
// Word and timing
`define INSTR_W 14
`define OSC_PER_ICYC 4
`define PHASE_W 2
`define PHASE_FIRST 2'h0
`define PHASE_LAST 2'h3
`define CYC_ONE 2'h1

// ==========================================================================
// Field positions
`define BYTE_OP_LSB 8
`define BYTE_D_BIT 7
`define FILE_MSB 6
`define BIT_OP_LSB 10
`define BIT_NUM_MSB 9
`define BIT_NUM_LSB 7
`define BIT_SKIP_BIT 11
`define LIT_MSB 7
`define JUMP_OP_LSB 11
`define JUMP_K_MSB 10
`define PAGE_OP_LSB 7
`define PAGE_K_MSB 6
`define BANK_OP_LSB 5
`define BANK_K_MSB 4
`define REL_OP_LSB 9
`define REL_K_MSB 8
`define PTRO_OP_LSB 7
`define PTRO_N_BIT 6
`define PTRO_K_MSB 5
`define PTRO_MEM_BIT 11
`define PTRI_OP_LSB 3
`define PTRI_N_BIT 2
`define PTRI_M_MSB 1

// ==========================================================================
// File address range and indirect access locations
`define FILE_ADDR_MIN 7'h00
`define FILE_ADDR_MAX 7'h7f
`define INDIRECT0_ADDR 7'h00
`define INDIRECT1_ADDR 7'h01

// ==========================================================================
// Format patterns, checked in priority order
`define PAT_PTR_INC 14'b0000000001????
`define PAT_BANK 14'b000000001?????
`define PAT_OPONLY 14'b0000000???????
`define PAT_CLRW 14'b00000100000???
`define PAT_BYTE 14'b00????????????
`define PAT_BIT 14'b01????????????
`define PAT_JUMP 14'b10????????????
`define PAT_REL 14'b11001?????????
`define PAT_PAGE 14'b1100011???????
`define PAT_ADD_PTR 14'b1100010???????
`define PAT_PTR_MEM 14'b111111????????
`define PAT_BYTE_X1 14'b110101????????
`define PAT_BYTE_X2 14'b11011?????????
`define PAT_BYTE_X3 14'b111101????????
`define PAT_BYTE_X4 14'b111011????????
`define PAT_LIT 14'b11????????????

// ==========================================================================
// Multi-cycle and skip opcodes
`define PAT_CALL 14'b100???????????
`define PAT_JUMP_ABS 14'b101???????????
`define PAT_RETLIT 14'b110100????????
`define OP_SUB_RETURN 14'h0008
`define OP_INT_RETURN 14'h0009
`define OP_WREG_CALL 14'h000a
`define OP_WREG_BRANCH 14'h000b
`define PAT_DEC_SKIP 14'b001011????????
`define PAT_INC_SKIP 14'b001111????????
`define PAT_SKIP_CLR 14'b0110??????????
`define PAT_SKIP_SET 14'b0111??????????

`endif

//--- common/decoder_pkg.sv
// Types of the 14-bit instruction decoder: formats, sequencer states, state records.
// Assumes decoder_map.svh on the include path.
`include "decoder_map.svh"

package decoder_pkg;

  // ========================================================================
  // Instruction formats
  typedef enum logic [9:0] {
    FMT_BYTE = 10'h001,
    FMT_BIT = 10'h002,
    FMT_LIT = 10'h004,
    FMT_JUMP = 10'h008,
    FMT_PAGE = 10'h010,
    FMT_BANK = 10'h020,
    FMT_REL = 10'h040,
    FMT_PTR_OFS = 10'h080,
    FMT_PTR_INC = 10'h100,
    FMT_OPONLY = 10'h200
  } fmt_t;

  // ========================================================================
  // Instruction cycle kinds
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_EXEC = 4'h2,
    ST_EXTRA = 4'h4,
    ST_FLUSH = 4'h8
  } seq_t;

  // ========================================================================
  // State records
  typedef struct packed {
    seq_t seq;
    fmt_t fmt;
    logic [`INSTR_W-1:0] opcode;
    logic dest_file;
    logic [`FILE_MSB:0] file_addr;
    logic [2:0] bit_num;
    logic [10:0] literal;
    logic ptr_sel;
    logic [1:0] ptr_mode;
    logic file_read;
    logic file_write;
    logic w_write;
    logic changes_pc;
    logic skip_kind;
    logic [1:0] cycles;
    logic extra_pend;
    logic flush_pend;
    logic exec_valid;
    logic nop_cycle;
    logic stall_cycle;
    logic fetch_take;
  } dec_state_t;

  typedef struct packed {
    logic [`PHASE_W-1:0] phase;
    logic last;
  } phase_state_t;

endpackage : decoder_pkg

//--- verilog/quad_phase_gen.sv
// Instruction cycle phase generator: four clocks make one instruction cycle.
// Assumes clk is the oscillator-rate core clock and rst_n an async active-low reset.
`timescale 1ns/1ps

module quad_phase_gen
  import decoder_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  output logic [`PHASE_W-1:0] phase,
  output logic cycle_last
);

  phase_state_t q;
  phase_state_t d;

  // ========================================================================
  // Phase counter
  always_comb begin
    d.phase = q.phase + 2'h1;
    d.last = (d.phase == `PHASE_LAST);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{phase: `PHASE_FIRST, last: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign phase = q.phase;
  assign cycle_last = q.last;

endmodule : quad_phase_gen

//--- verif/instr_decoder_properties.sv
// Checker of instruction cycle timing and decoded field relations.
// Assumes it is bound to instr_decoder; one clock domain.
`timescale 1ns/1ps

module instr_decoder_checker
  import decoder_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic skip_cond,
  input wire logic [`PHASE_W-1:0] phase,
  input wire logic cycle_last,
  input wire logic fetch_take,
  input wire logic exec_valid,
  input wire logic nop_cycle,
  input wire logic stall_cycle,
  input wire fmt_t fmt,
  input wire logic [`INSTR_W-1:0] opcode,
  input wire logic dest_file,
  input wire logic [10:0] literal,
  input wire logic file_read,
  input wire logic file_write,
  input wire logic w_write,
  input wire logic changes_pc,
  input wire logic skip_kind,
  input wire logic [1:0] cycles
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic exec_end = exec_valid && cycle_last;

  // ==========
  // Assertions
  a_phase_step: assert property (1'b1 |=> phase == $past(phase) + 2'h1)
    else $error("phase did not advance by one");
  a_last_phase: assert property (cycle_last == (phase == 2'h3))
    else $error("cycle_last not in phase 3");
  a_take_spacing: assert property (fetch_take |-> (phase == 2'h0) ##1 (!fetch_take) [*3])
    else $error("take not one in four clocks");
  a_exec_span: assert property (fetch_take |-> exec_valid [*4])
    else $error("execute cycle shorter than four clocks");
  a_single_next: assert property (
    exec_end && cycles == 2'h1 && !skip_kind && instr_valid |=> fetch_take)
    else $error("one-cycle instruction held the next take");
  a_pc_flush: assert property (
    exec_end && changes_pc && cycles == 2'h2 |=> nop_cycle [*4])
    else $error("no flush cycle after pc change");
  a_indirect_stall: assert property (
    exec_end && !changes_pc && !skip_kind && cycles == 2'h2 |=> stall_cycle [*4])
    else $error("no extra cycle for indirect access");
  a_skip_flush: assert property (
    exec_end && skip_kind && skip_cond && cycles == 2'h1 |=> nop_cycle [*4])
    else $error("true skip not followed by flush");
  a_skip_pass: assert property (
    exec_end && skip_kind && !skip_cond && cycles == 2'h1 && instr_valid |=> fetch_take)
    else $error("false skip delayed the next take");
  a_dest_route: assert property (
    exec_valid && fmt == FMT_BYTE && file_read |-> file_write == dest_file && w_write == !dest_file)
    else $error("destination select misrouted");
  a_rmw_read: assert property (file_write |-> file_read)
    else $error("file write without read");
  a_fields_hold: assert property (!fetch_take |-> $stable(opcode) && $stable(literal))
    else $error("fields changed without a take");

  c_call_take: cover property (fetch_take && changes_pc);
  c_stall_seen: cover property (stall_cycle && cycle_last);
  c_skip_true: cover property (exec_end && skip_kind && skip_cond);
endmodule : instr_decoder_checker

bind instr_decoder instr_decoder_checker instr_decoder_checker_i (.clk, .rst_n, .instr_valid,
  .skip_cond, .phase, .cycle_last, .fetch_take, .exec_valid, .nop_cycle, .stall_cycle, .fmt,
  .opcode, .dest_file, .literal, .file_read, .file_write, .w_write, .changes_pc, .skip_kind,
  .cycles);

//--- verif/fetch_model.sv
// Program memory fetch model: offers queued words until each is taken.
// Assumes the bench fills words and drives slow at the falling edge.
`timescale 1ns/1ps

module fetch_model
  import decoder_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fetch_take,
  input wire logic slow,
  output logic [`INSTR_W-1:0] instr_word,
  output logic instr_valid
);
  logic [`INSTR_W-1:0] words[$];
  int gap;

  initial begin
    instr_word = 14'h0000;
    instr_valid = 1'b0;
    gap = 0;
  end

  // ==========
  // Offer one whole word, hold it until taken
  always @(negedge clk) begin
    if (fetch_take === 1'b1 && words.size() > 0) begin
      void'(words.pop_front());
      gap = slow ? 6 : 0;
    end
    if (gap > 0) gap = gap - 1;
    if (rst_n && gap == 0 && words.size() > 0) begin
      instr_word <= words[0];
      instr_valid <= 1'b1;
    end else begin
      // Idle word toggles so nothing stale looks valid
      instr_word <= ~instr_word;
      instr_valid <= 1'b0;
    end
  end
endmodule : fetch_model

//--- verif/fourteen_bit_instruction_decoder_bench.sv
// Self-checking bench of the instruction decoder with a fetch model.
// Assumes decoder_pkg, the checker and the fetch model compiled first.
`timescale 1ns/1ps

module fourteen_bit_instruction_decoder_bench import decoder_pkg::*;;
  typedef struct {
    logic [13:0] w;
    fmt_t f;
    logic [1:0] c;
    logic cw;
  } note_t;
  localparam logic [13:0] base_tab [13] = '{14'h0700, 14'h1400, 14'h3000, 14'h2000, 14'h2800,
    14'h3180, 14'h0020, 14'h3200, 14'h3100, 14'h0010, 14'h3400, 14'h0008, 14'h0000};
  localparam logic [13:0] mask_tab [13] = '{14'h00ff, 14'h03ff, 14'h00ff, 14'h07ff, 14'h07ff,
    14'h007f, 14'h001f, 14'h01ff, 14'h007f, 14'h000f, 14'h00ff, 14'h0003, 14'h0000};
  localparam fmt_t fmt_tab [13] = '{FMT_BYTE, FMT_BIT, FMT_LIT, FMT_JUMP, FMT_JUMP, FMT_PAGE,
    FMT_BANK, FMT_REL, FMT_PTR_OFS, FMT_PTR_INC, FMT_LIT, FMT_OPONLY, FMT_OPONLY};
  localparam logic [1:0] cyc_tab [13] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h2,
    2'h1, 2'h1, 2'h2, 2'h2, 2'h1};
  localparam logic [13:0] skip_tab [4] = '{14'h1800, 14'h1c00, 14'h0b00, 14'h0f00};

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic skip_cond = 1'b0;
  logic [1:0] ptr_in_prog = 2'h0;
  logic slow = 1'b0;
  logic [13:0] instr_word, opcode;
  logic [10:0] literal;
  logic [6:0] file_addr;
  logic [2:0] bit_num;
  logic [1:0] phase, ptr_mode, cycles;
  logic instr_valid, cycle_last, fetch_take, exec_valid, nop_cycle, stall_cycle, dest_file;
  logic ptr_sel, file_read, file_write, w_write, changes_pc, skip_kind;
  fmt_t fmt;
  note_t exp_q[$];
  note_t got;
  int sh;
  int k;
  int n_errors = 0;
  int checks_done = 0;

  instr_decoder instr_decoder_i (.clk, .rst_n, .instr_word, .instr_valid, .skip_cond,
    .ptr_in_prog, .phase, .cycle_last, .fetch_take, .exec_valid, .nop_cycle, .stall_cycle,
    .fmt, .opcode, .dest_file, .file_addr, .bit_num, .literal, .ptr_sel, .ptr_mode,
    .file_read, .file_write, .w_write, .changes_pc, .skip_kind, .cycles);
  fetch_model fetch_model_i (.clk, .rst_n, .fetch_take, .slow, .instr_word, .instr_valid);

  initial forever #2 clk = ~clk;

  // ==========
  // Shared tasks
  task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic send(input logic [13:0] w, input fmt_t f, input logic [1:0] c, input logic cw);
    note_t n;
    if ((f == FMT_BYTE || f == FMT_BIT) && w[6:1] == 6'h00 && ptr_in_prog[w[0]]) c = c + 2'h1;
    n.w = w;
    n.f = f;
    n.c = c;
    n.cw = cw;
    exp_q.push_back(n);
    fetch_model_i.words.push_back(w);
  endtask : send

  task automatic drain(input string t);
    int i;
    for (i = 0; i < 3000 && exp_q.size() > 0; i++) @(negedge clk);
    if (exp_q.size() > 0) begin
      n_errors++;
      $display("Error drain %s expected 0 seen %0d", t, exp_q.size());
      results();
    end
    repeat (12) @(negedge clk);
    $display("Test %s done", t);
  endtask : drain

  function automatic int sh_of(fmt_t f);
    case (f)
      FMT_BYTE, FMT_LIT: return 8;
      FMT_BIT: return 10;
      FMT_JUMP: return 11;
      FMT_PAGE, FMT_PTR_OFS: return 7;
      FMT_BANK: return 5;
      FMT_REL: return 9;
      FMT_PTR_INC: return 3;
      default: return 0;
    endcase
  endfunction : sh_of

  // ==========
  // Result watcher
  always @(negedge clk) begin
    if (rst_n && fetch_take === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("spare take", 14'h0000, 14'h0001);
      end else begin
        got = exp_q.pop_front();
        sh = sh_of(got.f);
        chk("cycles", 14'(got.c), 14'(cycles));
        chk("exec_valid", 14'h0001, 14'(exec_valid));
        if (got.cw) begin
          chk("clrw file_addr", 14'h0000, 14'(file_addr));
          chk("clrw w_write", 14'h0001, 14'(w_write));
          chk("clrw file_read", 14'h0000, 14'(file_read));
        end else begin
          chk("fmt", 14'(got.f), 14'(fmt));
          chk("opcode", got.w >> sh, opcode);
        end
        if (got.f == FMT_BYTE || got.f == FMT_BIT) begin
          chk("file_addr", 14'(got.w[6:0]), 14'(file_addr));
          chk("file_read", 14'h0001, 14'(file_read));
        end
        if (got.f == FMT_BYTE) chk("dest_file", 14'(got.w[7]), 14'(dest_file));
        if (got.f == FMT_BYTE && !got.cw) begin
          chk("file_write", 14'(got.w[7]), 14'(file_write));
          chk("w_write", 14'(!got.w[7]), 14'(w_write));
        end
        if (got.f == FMT_BIT) begin
          chk("bit file_write", 14'(!got.w[11]), 14'(file_write));
          chk("bit w_write", 14'h0000, 14'(w_write));
        end
        chk("skip_kind", 14'((got.f == FMT_BIT && got.w[11]) || (got.f == FMT_BYTE
          && got.w[13:12] == 2'h0 && got.w[11:8] inside {4'hb, 4'hf})), 14'(skip_kind));
        if (!(got.f inside {FMT_BYTE, FMT_BIT, FMT_PTR_OFS, FMT_PTR_INC}))
          chk("changes_pc", 14'(got.c == 2'h2), 14'(changes_pc));
        if (got.f == FMT_BIT) chk("bit_num", 14'(got.w[9:7]), 14'(bit_num));
        if (got.f inside {FMT_LIT, FMT_JUMP, FMT_PAGE, FMT_BANK, FMT_REL})
          chk("literal", got.w & ~(14'h3fff << sh), 14'(literal));
        if (got.f == FMT_PTR_OFS) chk("offset", got.w & 14'h003f, 14'(literal));
        if (got.f inside {FMT_PTR_OFS, FMT_PTR_INC})
          chk("ptr_sel", 14'(got.f == FMT_PTR_OFS ? got.w[6] : got.w[2]), 14'(ptr_sel));
        if (got.f == FMT_PTR_INC) chk("ptr_mode", 14'(got.w[1:0]), 14'(ptr_mode));
      end
    end
  end

  // ==========
  // Scenarios
  initial begin
    void'($urandom(32'h058eccd4));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 39; i++) begin
      k = i % 13;
      send(base_tab[k] | (14'($urandom) & mask_tab[k]), fmt_tab[k], cyc_tab[k], 1'b0);
    end
    drain("formats");
    for (int p = 1; p < 4; p++) begin
      ptr_in_prog = 2'(p);
      send(14'h0780, FMT_BYTE, 2'h1, 1'b0);
      send(14'h0781, FMT_BYTE, 2'h1, 1'b0);
      send(14'h1700, FMT_BIT, 2'h1, 1'b0);
      send(14'h14ff, FMT_BIT, 2'h1, 1'b0);
      send(14'h3f40, FMT_PTR_OFS, 2'h1 + 2'(p[1]), 1'b0);
      drain("indirect");
    end
    ptr_in_prog = 2'h0;
    for (int s = 0; s < 2; s++) begin
      skip_cond = s[0];
      for (int j = 0; j < 4; j++) begin
        send(skip_tab[j] | (14'($urandom) & 14'h00ff), j < 2 ? FMT_BIT : FMT_BYTE, 2'h1, 1'b0);
        send(14'h3055, FMT_LIT, 2'h1, 1'b0);
      end
      drain("skip");
    end
    send(14'h0100, FMT_OPONLY, 2'h1, 1'b1);
    send(14'h0103, FMT_OPONLY, 2'h1, 1'b1);
    drain("dont care");
    slow = 1'b1;
    for (k = 0; k < 13; k++) send(base_tab[k] | mask_tab[k], fmt_tab[k], cyc_tab[k], 1'b0);
    drain("slow fetch");
    slow = 1'b0;
    send(14'h2000, FMT_JUMP, 2'h2, 1'b0);
    repeat (6) @(negedge clk);
    rst_n = 1'b0;
    exp_q.delete();
    fetch_model_i.words.delete();
    @(negedge clk);
    chk("reset phase", 14'h0000, 14'(phase));
    chk("reset nop", 14'h0001, 14'(nop_cycle));
    chk("reset fmt", 14'(FMT_OPONLY), 14'(fmt));
    chk("reset exec", 14'h0000, 14'(exec_valid));
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    send(14'h30aa, FMT_LIT, 2'h1, 1'b0);
    send(14'h0008, FMT_OPONLY, 2'h2, 1'b0);
    drain("reset");
    results();
  end
endmodule : fourteen_bit_instruction_decoder_bench
